// [design/acctd_pkg.sv]
// constants shared by the transient acceleration detector
package acctd_pkg;
    localparam int unsigned  NUM_AXES      = 3;
    localparam int unsigned  SAMPLE_W      = 14;
    localparam int unsigned  THS_W         = 7;
    localparam int unsigned  CNT_W         = 8;
    localparam int unsigned  REG_W         = 8;
    localparam int unsigned  ADR_W         = 10;
    // low-pass tracker inside the high-pass filter: fraction bits and corner shift
    localparam int unsigned  HPF_FRAC      = 6;
    localparam int unsigned  HPF_SHIFT     = 4;
    // 63 mg per threshold step against 14-bit samples at +-8 g (about 64 codes)
    localparam int unsigned  THS_SHIFT     = 6;

    // register indices; byte address is four times the index
    localparam logic [7:0]   IDX_CFG       = 8'h1D;
    localparam logic [7:0]   IDX_SRC       = 8'h1E;
    localparam logic [7:0]   IDX_THS       = 8'h1F;
    localparam logic [7:0]   IDX_COUNT     = 8'h20;
    localparam logic [7:0]   IDX_IRQ_STAT  = 8'h21;
    localparam logic [7:0]   IDX_IRQ_CLR   = 8'h22;
    localparam logic [7:0]   IDX_IRQ_EN    = 8'h23;

    // ac_event_config fields
    localparam int unsigned  CFG_HPF_BYP   = 0;
    localparam int unsigned  CFG_XEFE      = 1;
    localparam int unsigned  CFG_ELE       = 4;
    localparam logic [7:0]   CFG_MASK      = 8'h1F;
    // ac_event_source fields: axis i polarity at 2*i, flag at 2*i+1
    localparam int unsigned  SRC_EA        = 6;
    // threshold register fields
    localparam int unsigned  THS_MODE      = 7;
    // interrupt status bit
    localparam int unsigned  IRQ_EVENT     = 0;
    localparam logic [7:0]   IRQ_MASK      = 8'h01;

    localparam logic [7:0]   RST_REG       = 8'h00;
endpackage

// [design/acctd_axis_if.sv]
// per-axis carrier between the detector core and one axis evaluator
interface acctd_axis_if;
    import acctd_pkg::*;
    logic                       sample_valid;
    logic signed [SAMPLE_W-1:0] sample;
    logic                       enable;
    logic                       bypass;
    logic                       clear_mode;
    logic [THS_W-1:0]           threshold;
    logic [CNT_W-1:0]           target;
    logic                       done;
    logic                       hit;
    logic                       pol;

    modport core (output sample_valid, sample, enable, bypass, clear_mode, threshold, target,
                  input done, hit, pol);
    modport axis (input sample_valid, sample, enable, bypass, clear_mode, threshold, target,
                  output done, hit, pol);
endinterface

// [design/acctd_axis.sv]
// one axis: optional high-pass filter, threshold compare and debounce counter
module acctd_axis
    import acctd_pkg::*;
(
    // clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic ce_i,
    // carrier to the core
    acctd_axis_if.axis ax
);
    localparam int unsigned ACC_W = SAMPLE_W + HPF_FRAC + 1;

    logic signed [ACC_W-1:0]    lp_acc;
    logic signed [ACC_W-1:0]    diff;
    logic signed [SAMPLE_W:0]   filt;
    logic signed [SAMPLE_W:0]   data;
    logic        [SAMPLE_W:0]   mag;
    logic        [SAMPLE_W:0]   limit;
    logic                       exceeds;
    logic                       reached;
    logic        [CNT_W-1:0]    cnt;

    // the tracker follows the static offset; subtracting it leaves the ac part
    // sign bit repeated on purpose: zero extension would turn negative samples into large positive ones
    assign diff  = {ax.sample[SAMPLE_W-1], ax.sample, {HPF_FRAC{1'b0}}} - lp_acc;
    assign filt  = diff[ACC_W-1:HPF_FRAC];
    assign data  = ax.bypass ? (SAMPLE_W+1)'(ax.sample) : filt;
    assign mag   = data[SAMPLE_W] ? (SAMPLE_W+1)'(-data) : data;
    assign limit = (SAMPLE_W+1)'({ax.threshold, {THS_SHIFT{1'b0}}});
    assign exceeds = ax.enable && (mag > limit);
    assign reached = exceeds && ({1'b0, cnt} + 9'h001 >= {1'b0, ax.target});

    // filter keeps tracking while bypassed so re-enabling it does not glitch
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            lp_acc <= '0;
        end else if (ce_i && ax.sample_valid) begin
            lp_acc <= lp_acc + (diff >>> HPF_SHIFT);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt <= '0;
        end else if (ce_i && ax.sample_valid) begin
            if (exceeds) begin
                if (cnt != 8'hFF) begin
                    cnt <= cnt + 8'h01;
                end
            end else if (ax.clear_mode) begin
                cnt <= '0;
            end else if (cnt != 8'h00) begin
                cnt <= cnt - 8'h01;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ax.done <= 1'b0;
            ax.hit  <= 1'b0;
            ax.pol  <= 1'b0;
        end else if (ce_i) begin
            ax.done <= ax.sample_valid;
            if (ax.sample_valid) begin
                ax.hit <= reached;
                ax.pol <= data[SAMPLE_W];
            end
        end
    end
endmodule

// [design/acctd_top.sv]
// transient acceleration detector with wishbone registers and interrupt
module acctd_top
    import acctd_pkg::*;
(
    // clock, reset, clock enable
    input  wire logic                       clk_i,
    input  wire logic                       rst_i,
    input  wire logic                       ce_i,
    // acceleration samples, one strobe per output data period
    input  wire logic                       sample_valid_i,
    input  wire logic signed [SAMPLE_W-1:0] acc_x_i,
    input  wire logic signed [SAMPLE_W-1:0] acc_y_i,
    input  wire logic signed [SAMPLE_W-1:0] acc_z_i,
    // wishbone classic slave
    input  wire logic                       wb_cyc_i,
    input  wire logic                       wb_stb_i,
    input  wire logic                       wb_we_i,
    input  wire logic [ADR_W-1:0]           wb_adr_i,
    input  wire logic [3:0]                 wb_sel_i,
    input  wire logic [31:0]                wb_dat_i,
    output logic      [31:0]                wb_dat_o,
    output logic                            wb_ack_o,
    // interrupt
    output logic                            irq_o
);
    logic [REG_W-1:0]           ac_event_config;
    logic [REG_W-1:0]           ac_event_source;
    logic [REG_W-1:0]           ths_reg;
    logic [CNT_W-1:0]           debounce_target;
    logic [REG_W-1:0]           irq_status;
    logic [REG_W-1:0]           irq_enable;
    logic [REG_W-1:0]           next_source;
    logic [NUM_AXES-1:0]        hits;
    logic [NUM_AXES-1:0]        pols;
    logic [NUM_AXES-1:0]        dones;
    logic signed [SAMPLE_W-1:0] samples [NUM_AXES];
    logic                       access;
    logic                       wr;
    logic                       rd_src;
    logic                       eval;
    logic                       any_hit;
    logic [7:0]                 idx;

    assign samples[0] = acc_x_i;
    assign samples[1] = acc_y_i;
    assign samples[2] = acc_z_i;

    for (genvar i = 0; i < NUM_AXES; i++) begin : g_axis
        acctd_axis_if ax_if ();
        assign ax_if.sample_valid = sample_valid_i;
        assign ax_if.sample       = samples[i];
        assign ax_if.enable       = ac_event_config[CFG_XEFE+i];
        assign ax_if.bypass       = ac_event_config[CFG_HPF_BYP];
        assign ax_if.clear_mode   = ths_reg[THS_MODE];
        assign ax_if.threshold    = ths_reg[THS_W-1:0];
        assign ax_if.target       = debounce_target;
        assign hits[i]            = ax_if.hit;
        assign pols[i]            = ax_if.pol;
        assign dones[i]           = ax_if.done;
        acctd_axis u_axis (
            .clk_i (clk_i),
            .rst_i (rst_i),
            .ce_i  (ce_i),
            .ax    (ax_if.axis)
        );
    end

    // bus decode; the ack cycle is the one in which writes and read side effects land
    assign idx    = wb_adr_i[ADR_W-1:2];
    assign access = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr     = access && wb_we_i && wb_sel_i[0];
    assign rd_src = access && !wb_we_i && (idx == IDX_SRC);
    assign eval    = &dones;
    assign any_hit = |hits;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
        end else if (ce_i) begin
            wb_ack_o <= access;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= '0;
        end else if (ce_i && access) begin
            unique case (idx)
                IDX_CFG:      wb_dat_o <= {24'h000000, ac_event_config};
                IDX_SRC:      wb_dat_o <= {24'h000000, ac_event_source};
                IDX_THS:      wb_dat_o <= {24'h000000, ths_reg};
                IDX_COUNT:    wb_dat_o <= {24'h000000, debounce_target};
                IDX_IRQ_STAT: wb_dat_o <= {24'h000000, irq_status};
                IDX_IRQ_EN:   wb_dat_o <= {24'h000000, irq_enable};
                default:      wb_dat_o <= '0;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ac_event_config <= RST_REG;
            ths_reg         <= RST_REG;
            debounce_target <= RST_REG;
            irq_enable      <= RST_REG;
        end else if (ce_i && wr) begin
            if (idx == IDX_CFG) begin
                ac_event_config <= wb_dat_i[7:0] & CFG_MASK;
            end
            if (idx == IDX_THS) begin
                ths_reg <= wb_dat_i[7:0];
            end
            if (idx == IDX_COUNT) begin
                debounce_target <= wb_dat_i[7:0];
            end
            if (idx == IDX_IRQ_EN) begin
                irq_enable <= wb_dat_i[7:0] & IRQ_MASK;
            end
        end
    end

    // a read clears first, then a same-cycle evaluation sets, so no event is lost
    always_comb begin
        next_source = rd_src ? RST_REG : ac_event_source;
        if (eval) begin
            if (ac_event_config[CFG_ELE]) begin
                if (any_hit && !next_source[SRC_EA]) begin
                    next_source[SRC_EA] = 1'b1;
                    for (int i = 0; i < NUM_AXES; i++) begin
                        next_source[2*i+1] = hits[i];
                        next_source[2*i]   = hits[i] & pols[i];
                    end
                end
            end else begin
                next_source[SRC_EA] = any_hit;
                for (int i = 0; i < NUM_AXES; i++) begin
                    if (hits[i]) begin
                        next_source[2*i+1] = 1'b1;
                        next_source[2*i]   = pols[i];
                    end
                end
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ac_event_source <= RST_REG;
        end else if (ce_i) begin
            ac_event_source <= next_source;
        end
    end

    // sticky status: a clear and a new event in one cycle leave the bit set
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_status <= RST_REG;
        end else if (ce_i) begin
            if (wr && idx == IDX_IRQ_CLR) begin
                irq_status <= irq_status & ~wb_dat_i[7:0];
            end
            if (eval && any_hit) begin
                irq_status[IRQ_EVENT] <= 1'b1;
            end
        end
    end

    assign irq_o = |(irq_status & irq_enable);
endmodule

// [verif/acctd_top_asserts.sv]
// port-level assertions for the transient detector
module acctd_top_asserts (
    // clock and reset
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        ce_i,
    // watched ports
    input wire logic        sample_valid_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        irq_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ack_timing_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i |=> wb_ack_o)
        else $error("request not acknowledged");
    ack_pulse_a: assert property (wb_ack_o && ce_i |=> !wb_ack_o) else $error("ack too long");
    ack_cause_a: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i)) else $error("stray ack");
    dat_upper_a: assert property (wb_dat_o[31:8] == 24'h0) else $error("read data upper bits set");
    dat_hold_a: assert property ($changed(wb_dat_o) |-> wb_ack_o) else $error("read data moved");
    // an event shows two edges after its sample; only a register write can raise it otherwise
    irq_rise_a: assert property ($rose(irq_o) |-> $past(sample_valid_i, 2) || $past(wb_cyc_i && wb_we_i))
        else $error("interrupt without cause");
    irq_fall_a: assert property ($fell(irq_o) |-> $past(wb_cyc_i && wb_stb_i && wb_we_i))
        else $error("interrupt dropped without write");
    reset_quiet_a: assert property ($fell(rst_i) |-> !wb_ack_o && !irq_o && wb_dat_o == 32'h0)
        else $error("outputs active after reset");
    freeze_hold_a: assert property (!ce_i |=> $stable(wb_ack_o) && $stable(wb_dat_o) && $stable(irq_o))
        else $error("outputs moved while clock enable low");
endmodule

bind acctd_top acctd_top_asserts u_acctd_top_asserts (.clk_i, .rst_i, .ce_i, .sample_valid_i, .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_dat_o, .wb_ack_o, .irq_o);

// [verif/acctd_top_test.sv]
// self-checking bench for the transient acceleration detector
module acctd_top_test
    import acctd_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic                       clk_i = 1'b0;
    logic                       rst_i = 1'b1;
    logic                       ce_i = 1'b1;
    logic                       sample_valid_i = 1'b0;
    logic signed [SAMPLE_W-1:0] acc_x_i = '0, acc_y_i = '0, acc_z_i = '0;
    logic                       wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [ADR_W-1:0]           wb_adr_i = '0;
    logic [3:0]                 wb_sel_i = 4'h0;
    logic [31:0]                wb_dat_i = 32'h0;
    logic [31:0]                wb_dat_o;
    logic                       wb_ack_o;
    logic                       irq_o;
    logic [31:0]                rng = 32'h9F4D67F3;
    logic [7:0]                 exp_q[$];
    logic [7:0]                 idxs[6] = '{IDX_CFG, IDX_SRC, IDX_THS, IDX_COUNT, IDX_IRQ_EN, 8'h40};
    int                         seq[6] = '{0, 200, 200, 0, 200, 200};
    int                         err_total = 0, checked = 0, cycles = 0;

    // clock enable is lowered once to show that a frozen block ignores a strobe
    acctd_top u_acctd_top (.clk_i, .rst_i, .ce_i, .sample_valid_i, .acc_x_i, .acc_y_i, .acc_z_i,
        .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq_o);

    always #4 clk_i = ~clk_i;

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        checked++;
        if (seen !== want) begin
            err_total++;
            $display("CHECK FAILED %0t seen %h want %h", $time, seen, want);
        end
    endtask

    task automatic stop_test();
        if (err_total == 0 && checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    function automatic logic [31:0] xs();
        rng ^= rng << 13;
        rng ^= rng >> 17;
        rng ^= rng << 5;
        return rng;
    endfunction

    task automatic bus(input logic we, input logic [7:0] idx, input logic [7:0] d);
        @(posedge clk_i);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_sel_i} <= {2'b11, we, 4'hF};
        wb_adr_i <= {idx, 2'b00};
        wb_dat_i <= {24'h0, d};
        do @(posedge clk_i); while (wb_ack_o !== 1'b1);
        {wb_cyc_i, wb_stb_i} <= 2'b00;
    endtask

    task automatic rd(input logic [7:0] idx, input logic [7:0] want);
        exp_q.push_back(want);
        bus(1'b0, idx, 8'h00);
    endtask

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        bus(1'b1, idx, d);
    endtask

    // noise between strobes proves only the strobed sample is evaluated
    task automatic smp(input int x, input int y, input int z);
        @(posedge clk_i);
        sample_valid_i <= 1'b1;
        {acc_x_i, acc_y_i, acc_z_i} <= {SAMPLE_W'(x), SAMPLE_W'(y), SAMPLE_W'(z)};
        @(posedge clk_i);
        sample_valid_i <= 1'b0;
        {acc_x_i, acc_y_i, acc_z_i} <= 42'({xs(), xs()});
        repeat (3) @(posedge clk_i);
    endtask

    always @(posedge clk_i)
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) check(wb_dat_o, {24'h0, exp_q.pop_front()});

    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            err_total++;
            stop_test();
        end
    end

    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        foreach (idxs[i]) rd(idxs[i], 8'h00);
        wr(IDX_CFG, 8'hFF);
        rd(IDX_CFG, 8'h1F);
        wr(8'h40, 8'hAA);
        rd(8'h40, 8'h00);
        wr(IDX_CFG, 8'h03);
        wr(IDX_THS, 8'h02);
        wr(IDX_COUNT, 8'h03);
        wr(IDX_IRQ_EN, 8'h01);
        for (int i = 1; i < 5; i++) smp(seq[i], 0, 0);
        rd(IDX_SRC, 8'h00);
        check({31'h0, irq_o}, 32'h0);
        smp(200, 0, 0);
        rd(IDX_SRC, 8'h42);
        check({31'h0, irq_o}, 32'h1);
        wr(IDX_IRQ_EN, 8'h00);
        check({31'h0, irq_o}, 32'h0);
        wr(IDX_IRQ_EN, 8'h01);
        rd(IDX_IRQ_STAT, 8'h01);
        wr(IDX_IRQ_CLR, 8'h01);
        check({31'h0, irq_o}, 32'h0);
        wr(IDX_THS, 8'h82);
        foreach (seq[i]) smp(seq[i], 0, 0);
        rd(IDX_SRC, 8'h00);
        smp(-200, 0, 0);
        rd(IDX_SRC, 8'h43);
        wr(IDX_COUNT, 8'h00);
        wr(IDX_CFG, 8'h07);
        smp(200, 0, 0);
        smp(0, -300, 0);
        rd(IDX_SRC, 8'h4E);
        smp(200, 0, 0);
        smp(0, 0, 0);
        rd(IDX_SRC, 8'h02);
        wr(IDX_CFG, 8'h09);
        smp(0, -500, 300 + int'(xs() & 32'h0FFF));
        rd(IDX_SRC, 8'h60);
        wr(IDX_CFG, 8'h17);
        smp(-200, 0, 0);
        smp(0, 300, 0);
        rd(IDX_SRC, 8'h43);
        rd(IDX_SRC, 8'h00);
        wr(IDX_CFG, 8'h03);
        wr(IDX_THS, 8'h7F);
        smp(8128, 0, 0);
        rd(IDX_SRC, 8'h00);
        smp(-8129, 0, 0);
        rd(IDX_SRC, 8'h43);
        wr(IDX_THS, 8'h02);
        wr(IDX_CFG, 8'h02);
        repeat (80) smp(4000, 0, 0);
        rd(IDX_SRC, 8'h02);
        smp(4000, 0, 0);
        rd(IDX_SRC, 8'h00);
        wr(IDX_CFG, 8'h03);
        smp(4000, 0, 0);
        rd(IDX_SRC, 8'h42);
        ce_i <= 1'b0;
        smp(4000, 0, 0);
        ce_i <= 1'b1;
        rd(IDX_SRC, 8'h00);
        // let the watcher take the last read before the verdict
        repeat (2) @(posedge clk_i);
        check(exp_q.size(), 32'h0);
        stop_test();
    end
endmodule
